// ===== design/pxa_core.sv
// Serial-bus 16-bit quasi-bidirectional port expander core with change alert
`timescale 1ns/100ps
// Function
// RQ1: Any input pin edge raises the alert
// RQ2: Alert withdrawn when pins return to snapshot
// RQ3: Write-to-port pulse releases the alert
// RQ4: Read-from-port pulse clears the alert
// RQ5: Changes after clearing raise alert again
// RQ6: Alert is open-drain, pulls low only
// RQ7: START and STOP are SDA edges, SCL high
// RQ8: SDA stable while SCL high, one bit/pulse
// RQ9: Eight bits then one acknowledge bit
// RQ10: Device acknowledges each received byte low
// RQ11: Master NACK ends read, device releases SDA
// RQ12: Written bytes alternate low then high latch
// RQ13: Any write reloads snapshots, clears alerts
// RQ14: Pins sampled as each read byte starts
// RQ15: Low byte read clears only low causes
// RQ16: High byte read clears only high causes
// RQ17: Read returns pin level, inputs written high
// RQ18: Master starts only while bus idle
// RQ19: Address LSB selects write or read
// RQ20: Port latches high after reset
// RQ21: Per-byte snapshot compare detects pin changes
module pxa_core #(
   parameter logic [6:0] DEV_ADDR = pxa_pkg::PXA_DEV_ADDR  // Slave address
) (
   input  wire logic        sys_clk_i,   // 200 MHz core clock
   input  wire logic        arst_n_i,    // Async reset, active low
   input  wire logic        scl_i,       // Bus clock pin level
   output logic             scl_o,       // Bus clock drive level, always low
   output logic             scl_oe_o,    // Stretch bus clock low
   input  wire logic        sda_i,       // Bus data pin level
   output logic             sda_o,       // Bus data drive level, always low
   output logic             sda_oe_o,    // Pull bus data low
   input  wire logic [15:0] port_pins_i, // External pin levels
   output logic      [15:0] port_latch_o,// Port output latches
   input  wire logic        upd_ready_i, // Port update path accepts a byte
   output logic             alert_o,     // Alert drive level, always low
   output logic             alert_oe_o   // Pull alert low
);
   localparam int BW = pxa_pkg::PXA_BYTE_W + 1;  // Buffered word: select plus byte

   // All core state
   typedef struct packed {
      logic                 scl_m;    // Sync stage one
      logic                 scl_q;    // Sync stage two
      logic                 scl_p;    // Previous synced level
      logic                 sda_m;    // Sync stage one
      logic                 sda_q;    // Sync stage two
      logic                 sda_p;    // Previous synced level
      logic [15:0]          pin_m;    // Pin sync stage one
      logic [15:0]          pin_q;    // Pin sync stage two
      pxa_pkg::pxa_state_t  st;       // Protocol state
      logic [3:0]           bit_cnt;  // Bits in current byte
      logic [7:0]           shift;    // Byte shift register
      logic                 rw;       // Direction of this transfer
      logic                 hi_sel;   // Current byte is high port
      logic                 acked;    // Master acknowledged last read byte
      logic                 push_pend;// Received byte waits for buffer
      logic                 sda_oe;   // Data line pulled low
      logic [15:0]          latch;    // Port latches
      logic [7:0]           ref_lo;   // Low port snapshot
      logic [7:0]           ref_hi;   // High port snapshot
      logic                 alert;    // Alert asserted
   } pxa_st_t;

   localparam pxa_st_t ST_RST = '{
      scl_m: 1'b1, scl_q: 1'b1, scl_p: 1'b1,
      sda_m: 1'b1, sda_q: 1'b1, sda_p: 1'b1,
      pin_m: pxa_pkg::PXA_PIN_RST, pin_q: pxa_pkg::PXA_PIN_RST,
      st: pxa_pkg::PXA_IDLE, bit_cnt: 4'h0, shift: 8'h00,
      rw: 1'b0, hi_sel: 1'b0, acked: 1'b0, push_pend: 1'b0, sda_oe: 1'b0,
      latch: pxa_pkg::PXA_LATCH_RST,
      ref_lo: pxa_pkg::PXA_PIN_RST[7:0], ref_hi: pxa_pkg::PXA_PIN_RST[15:8],
      alert: 1'b0
   };

   pxa_st_t st_ff;   // Registered state
   pxa_st_t nxt_st;  // Next state

   logic          scl_rise;  // Synced clock rising
   logic          scl_fall;  // Synced clock falling
   logic          bus_start; // START seen
   logic          bus_stop;  // STOP seen
   logic          buf_in_rdy;// Buffer has room
   logic          upd_valid; // Buffered byte ready for latch
   logic [BW-1:0] upd_data;  // Buffered select and byte
   logic          upd_take;  // Byte moves into a latch

   // Pick one port byte from a 16-bit word
   function automatic logic [7:0] port_byte(input logic [15:0] w, input logic hi);
      port_byte = hi ? w[15:8] : w[7:0];
   endfunction

   // Edges and bus conditions from the synced lines
   assign scl_rise  = st_ff.scl_q & ~st_ff.scl_p;
   assign scl_fall  = ~st_ff.scl_q & st_ff.scl_p;
   assign bus_start = st_ff.scl_q & st_ff.scl_p & st_ff.sda_p & ~st_ff.sda_q;  // [RQ7]
   assign bus_stop  = st_ff.scl_q & st_ff.scl_p & ~st_ff.sda_p & st_ff.sda_q;  // [RQ7]
   assign upd_take  = upd_valid & upd_ready_i;

   // Open-drain pins only ever drive low
   assign scl_o        = 1'b0;
   assign sda_o        = 1'b0;
   assign alert_o      = 1'b0;
   assign sda_oe_o     = st_ff.sda_oe;
   assign scl_oe_o     = st_ff.push_pend & ~buf_in_rdy;  // Hold clock low, no byte lost
   assign alert_oe_o   = st_ff.alert;  // [RQ6]
   assign port_latch_o = st_ff.latch;

   // Received bytes wait here until the latch path takes them
   pxa_buf #(
      .WIDTH (BW),
      .DEPTH (pxa_pkg::PXA_BUF_DEPTH)
   ) u_buf (
      .sys_clk_i   (sys_clk_i),
      .arst_n_i    (arst_n_i),
      .in_valid_i  (st_ff.push_pend),
      .in_ready_o  (buf_in_rdy),
      .in_data_i   ({st_ff.hi_sel, st_ff.shift}),
      .out_valid_o (upd_valid),
      .out_ready_i (upd_ready_i),
      .out_data_o  (upd_data)
   );

   // Next-state logic
   always_comb begin
      nxt_st = st_ff;
      // Two-stage synchronisers; stage one feeds stage two only
      nxt_st.scl_m = scl_i;
      nxt_st.scl_q = st_ff.scl_m;
      nxt_st.scl_p = st_ff.scl_q;
      nxt_st.sda_m = sda_i;
      nxt_st.sda_q = st_ff.sda_m;
      nxt_st.sda_p = st_ff.sda_q;
      nxt_st.pin_m = port_pins_i;
      nxt_st.pin_q = st_ff.pin_m;

      // Buffer accepted the pending byte, release any stretch
      if (st_ff.push_pend & buf_in_rdy) begin
         nxt_st.push_pend = 1'b0;
         nxt_st.hi_sel    = ~st_ff.hi_sel;  // [RQ12]
      end

      if (bus_start) begin
         // START or repeated START begins a new address byte
         nxt_st.st      = pxa_pkg::PXA_ADDR;
         nxt_st.bit_cnt = 4'h0;
         nxt_st.sda_oe  = 1'b0;
      end else if (bus_stop) begin
         // STOP frees the bus
         nxt_st.st     = pxa_pkg::PXA_IDLE;
         nxt_st.sda_oe = 1'b0;
      end else begin
         unique case (st_ff.st)
            pxa_pkg::PXA_IDLE: begin
               // Wait for START
               nxt_st.sda_oe = 1'b0;
            end
            pxa_pkg::PXA_ADDR: begin
               if (scl_rise) begin
                  // Data sampled while clock high
                  nxt_st.shift   = {st_ff.shift[6:0], st_ff.sda_q};  // [RQ8]
                  nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
               end else if (scl_fall && st_ff.bit_cnt == pxa_pkg::PXA_BITS_BYTE) begin
                  if (st_ff.shift[7:1] == DEV_ADDR) begin
                     nxt_st.sda_oe = 1'b1;  // [RQ10]
                     nxt_st.rw     = st_ff.shift[0];  // [RQ19]
                     nxt_st.st     = pxa_pkg::PXA_ACK_ADDR;
                  end else begin
                     nxt_st.st = pxa_pkg::PXA_IDLE;
                  end
               end
            end
            pxa_pkg::PXA_ACK_ADDR: begin
               if (scl_fall) begin
                  nxt_st.bit_cnt = 4'h0;
                  nxt_st.hi_sel  = pxa_pkg::PXA_SEL_LO;
                  if (st_ff.rw == pxa_pkg::PXA_RW_READ) begin
                     // First read byte: sample low pins, refresh low snapshot
                     nxt_st.shift  = st_ff.pin_q[7:0];  // [RQ14] [RQ17]
                     nxt_st.ref_lo = st_ff.pin_q[7:0];  // [RQ4] [RQ15]
                     nxt_st.sda_oe = ~st_ff.pin_q[7];
                     nxt_st.st     = pxa_pkg::PXA_RD;
                  end else begin
                     nxt_st.sda_oe = 1'b0;
                     nxt_st.st     = pxa_pkg::PXA_WR;
                  end
               end
            end
            pxa_pkg::PXA_WR: begin
               if (scl_rise) begin
                  nxt_st.shift   = {st_ff.shift[6:0], st_ff.sda_q};  // [RQ8]
                  nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
               end else if (scl_fall && st_ff.bit_cnt == pxa_pkg::PXA_BITS_BYTE) begin
                  // Byte complete: queue it and acknowledge
                  nxt_st.push_pend = 1'b1;  // [RQ12]
                  nxt_st.sda_oe    = 1'b1;  // [RQ9] [RQ10]
                  nxt_st.st        = pxa_pkg::PXA_ACK_WR;
               end
            end
            pxa_pkg::PXA_ACK_WR: begin
               if (scl_fall && !st_ff.push_pend) begin
                  // Acknowledge slot over, next byte
                  nxt_st.sda_oe  = 1'b0;
                  nxt_st.bit_cnt = 4'h0;
                  nxt_st.st      = pxa_pkg::PXA_WR;
               end
            end
            pxa_pkg::PXA_RD: begin
               if (scl_fall) begin
                  if (st_ff.bit_cnt == pxa_pkg::PXA_LAST_BIT) begin
                     // Release data for master acknowledge
                     nxt_st.sda_oe = 1'b0;  // [RQ9]
                     nxt_st.st     = pxa_pkg::PXA_ACK_RD;
                  end else begin
                     nxt_st.shift   = {st_ff.shift[6:0], 1'b0};
                     nxt_st.sda_oe  = ~st_ff.shift[6];  // [RQ8]
                     nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
                  end
               end
            end
            pxa_pkg::PXA_ACK_RD: begin
               if (scl_rise) begin
                  nxt_st.acked = ~st_ff.sda_q;
               end else if (scl_fall) begin
                  if (st_ff.acked) begin
                     // Next read byte: sample that port, refresh its snapshot
                     nxt_st.hi_sel  = ~st_ff.hi_sel;
                     nxt_st.bit_cnt = 4'h0;
                     nxt_st.shift   = port_byte(st_ff.pin_q, ~st_ff.hi_sel);  // [RQ14]
                     nxt_st.sda_oe  = ~nxt_st.shift[7];  // MSB of the byte just loaded
                     nxt_st.st      = pxa_pkg::PXA_RD;
                     if (st_ff.hi_sel) begin
                        nxt_st.ref_lo = st_ff.pin_q[7:0];  // [RQ4] [RQ15]
                     end else begin
                        nxt_st.ref_hi = st_ff.pin_q[15:8];  // [RQ4] [RQ16]
                     end
                  end else begin
                     // Master NACK: keep data released until STOP
                     nxt_st.sda_oe = 1'b0;  // [RQ11]
                     nxt_st.st     = pxa_pkg::PXA_IDLE;
                  end
               end
            end
            default: begin
               nxt_st.st     = pxa_pkg::PXA_IDLE;
               nxt_st.sda_oe = 1'b0;
            end
         endcase
      end

      // Write-to-port pulse: load latch, refresh both snapshots
      if (upd_take) begin
         if (upd_data[BW-1]) begin
            nxt_st.latch[15:8] = upd_data[7:0];  // [RQ12]
         end else begin
            nxt_st.latch[7:0] = upd_data[7:0];  // [RQ12]
         end
         nxt_st.ref_lo = st_ff.pin_q[7:0];  // [RQ13]
         nxt_st.ref_hi = st_ff.pin_q[15:8];  // [RQ13]
      end

      // Alert follows any difference from the snapshots
      nxt_st.alert = (st_ff.pin_q[7:0] != nxt_st.ref_lo)
                   | (st_ff.pin_q[15:8] != nxt_st.ref_hi);  // [RQ1] [RQ2] [RQ3] [RQ5] [RQ21]
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_ff <= ST_RST;  // [RQ20]
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule

// ===== include/pxa_pkg.sv
// Shared constants and types for the port expander core
package pxa_pkg;
   localparam logic [15:0] PXA_LATCH_RST = 16'hFFFF;  // Port latches high after reset
   localparam logic [15:0] PXA_PIN_RST   = 16'hFFFF;  // Pin sync and snapshot after reset
   localparam logic [6:0]  PXA_DEV_ADDR  = 7'h20;     // Default slave address, arbitrary
   localparam logic [3:0]  PXA_BITS_BYTE = 4'h8;      // Data bits per byte
   localparam logic [3:0]  PXA_LAST_BIT  = 4'h7;      // Index of last bit sent
   localparam int          PXA_BYTE_W    = 8;         // Port byte width
   localparam int          PXA_BUF_DEPTH = 2;         // Write buffer entries
   localparam logic        PXA_SEL_LO    = 1'b0;      // Byte select: low port
   localparam logic        PXA_RW_READ   = 1'b1;      // Direction bit value for read

   // Slave protocol states
   typedef enum logic [2:0] {
      PXA_IDLE     = 3'h0,
      PXA_ADDR     = 3'h1,
      PXA_ACK_ADDR = 3'h2,
      PXA_WR       = 3'h3,
      PXA_ACK_WR   = 3'h4,
      PXA_RD       = 3'h5,
      PXA_ACK_RD   = 3'h6
   } pxa_state_t;
endpackage

// ===== design/pxa_buf.sv
// Two-entry valid/ready buffer between the serial receiver and the port latches
`timescale 1ns/100ps
module pxa_buf #(
   parameter int WIDTH = 9,
   parameter int DEPTH = pxa_pkg::PXA_BUF_DEPTH
) (
   input  wire logic             sys_clk_i,
   input  wire logic             arst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;  // Pointer width
   localparam int CW = $clog2(DEPTH + 1);                // Fill count width

   // All buffer state
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;    // Storage
      logic [PW-1:0]               wr_ptr; // Next slot to fill
      logic [PW-1:0]               rd_ptr; // Oldest slot
      logic [CW-1:0]               count;  // Words held
   } pxa_buf_st_t;

   pxa_buf_st_t st_ff;   // Registered state
   pxa_buf_st_t nxt_st;  // Next state

   logic push;  // Word accepted
   logic pop;   // Word delivered

   // Advance a pointer with wrap
   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      if (p == PW'(DEPTH - 1)) begin
         bump = '0;
      end else begin
         bump = p + PW'(1);
      end
   endfunction

   // Honest full and empty flags
   assign in_ready_o  = (st_ff.count != CW'(DEPTH));
   assign out_valid_o = (st_ff.count != '0);
   assign out_data_o  = st_ff.mem[st_ff.rd_ptr];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // Next-state logic
   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wr_ptr] = in_data_i;
         nxt_st.wr_ptr            = bump(st_ff.wr_ptr);
      end
      if (pop) begin
         nxt_st.rd_ptr = bump(st_ff.rd_ptr);
      end
      if (push & ~pop) begin
         nxt_st.count = st_ff.count + CW'(1);
      end else if (pop & ~push) begin
         nxt_st.count = st_ff.count - CW'(1);
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule

// ===== testbench/pxa_core_properties.sv
// Concurrent checks on the expander core ports, bound into the core
`timescale 1ns/100ps
module pxa_core_properties (
   input wire logic        sys_clk_i,
   input wire logic        arst_n_i,
   input wire logic        scl_i,
   input wire logic        scl_o,
   input wire logic        scl_oe_o,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe_o,
   input wire logic [15:0] port_pins_i,
   input wire logic [15:0] port_latch_o,
   input wire logic        upd_ready_i,
   input wire logic        alert_o,
   input wire logic        alert_oe_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   // Open-drain pins only ever drive low
   property p_od; alert_o == 1'b0 && sda_o == 1'b0 && scl_o == 1'b0; endproperty
   a_od: assert property (p_od) else $error("open-drain level driven high");
   // First edge after reset: latches high, alert and data not pulled
   property p_rst_val;
      $rose(arst_n_i) |-> port_latch_o == 16'hFFFF && !alert_oe_o && !sda_oe_o;
   endproperty
   a_rst_val: assert property (p_rst_val) else $error("bad state after reset");
   // Latches move only when the update path accepts
   property p_latch_ready; $changed(port_latch_o) |-> $past(upd_ready_i); endproperty
   a_latch_ready: assert property (p_latch_ready) else $error("latch moved while stalled");
   // One byte lane per update
   property p_latch_step;
      $changed(port_latch_o) |-> port_latch_o[15:8] == $past(port_latch_o[15:8])
         || port_latch_o[7:0] == $past(port_latch_o[7:0]);
   endproperty
   a_latch_step: assert property (p_latch_step) else $error("both latch bytes moved");
   // Data pull starts only during the clock low phase
   property p_sda_rise; $rose(sda_oe_o) |-> !scl_i && !$past(scl_i, 2); endproperty
   a_sda_rise: assert property (p_sda_rise) else $error("data pulled while clock high");
   // A pulled bit stays for eight cycles after the clock rises
   property p_sda_hold; sda_oe_o && $rose(scl_i) |-> sda_oe_o [*8]; endproperty
   a_sda_hold: assert property (p_sda_hold) else $error("data dropped in high phase");
   // Device stays off the data line after a start
   property p_start_quiet; scl_i && $fell(sda_i) |-> !sda_oe_o [*8]; endproperty
   a_start_quiet: assert property (p_start_quiet) else $error("data pulled after start");
   // On an idle bus the alert moves only after a pin change
   property p_alert_cause;
      $changed(alert_oe_o) && scl_i && sda_i && upd_ready_i && $past(upd_ready_i, 4)
         |-> $past(port_pins_i, 2) != $past(port_pins_i, 3)
         || $past(port_pins_i, 3) != $past(port_pins_i, 4)
         || $past(port_pins_i, 4) != $past(port_pins_i, 5);
   endproperty
   a_alert_cause: assert property (p_alert_cause) else $error("alert moved without cause");
   // A port update with steady pins leaves no alert
   property p_write_clear;
      $changed(port_latch_o) && port_pins_i == $past(port_pins_i, 6) |-> ##[0:2] !alert_oe_o;
   endproperty
   a_write_clear: assert property (p_write_clear) else $error("alert kept after write");
   cover property ($rose(scl_oe_o));
   cover property ($rose(alert_oe_o));
   cover property ($changed(port_latch_o));
endmodule
bind pxa_core pxa_core_properties u_props (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
   .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .port_pins_i(port_pins_i), .port_latch_o(port_latch_o),
   .upd_ready_i(upd_ready_i), .alert_o(alert_o), .alert_oe_o(alert_oe_o));

// ===== testbench/pxa_master_model.sv
// Serial-bus master model with open-drain wire resolution
`timescale 1ns/100ps
module pxa_master_model (
   input  wire logic sys_clk_i,
   input  wire logic scl_oe_i,  // Device stretches the clock
   input  wire logic sda_oe_i,  // Device pulls data low
   output logic      scl_w_o,   // Resolved clock wire
   output logic      sda_w_o    // Resolved data wire
);
   logic m_scl_low;  // Master pulls clock low
   logic m_sda_low;  // Master pulls data low
   int   hung;       // Stretch waits that ran out
   // Pull-ups make released lines high
   assign scl_w_o = ~(m_scl_low | scl_oe_i);
   assign sda_w_o = ~(m_sda_low | sda_oe_i);
   // Both lines idle high, clock still outside frames
   initial begin
      m_scl_low = 1'b0;
      m_sda_low = 1'b0;
      hung      = 0;
   end
   // One pulse of 125 ns: data set mid-low, held while high
   task automatic bit_cyc(input logic b, output logic r);
      int n;
      n = 0;
      repeat (6) @(posedge sys_clk_i);
      m_sda_low <= ~b;
      repeat (7) @(posedge sys_clk_i);
      m_scl_low <= 1'b0;
      @(posedge sys_clk_i);
      while (!scl_w_o && n < 4000) begin
         n++;
         @(posedge sys_clk_i);
      end
      if (n >= 4000) hung++;
      repeat (11) @(posedge sys_clk_i);
      r = sda_w_o;
      m_scl_low <= 1'b1;
   endtask
   // Start only from idle
   task automatic start;
      @(posedge sys_clk_i);
      m_sda_low <= 1'b1;
      repeat (12) @(posedge sys_clk_i);
      m_scl_low <= 1'b1;
   endtask
   // Stop, then leave the bus idle
   task automatic stop;
      repeat (6) @(posedge sys_clk_i);
      m_sda_low <= 1'b1;
      repeat (7) @(posedge sys_clk_i);
      m_scl_low <= 1'b0;
      repeat (12) @(posedge sys_clk_i);
      m_sda_low <= 1'b0;
      repeat (12) @(posedge sys_clk_i);
   endtask
   // Eight bits MSB first, then the acknowledge slot
   task automatic wr_byte(input logic [7:0] d, output logic nak);
      logic r;
      for (int i = 7; i >= 0; i--) bit_cyc(d[i], r);
      bit_cyc(1'b1, nak);
   endtask
   // Read a byte; acknowledge all but the last
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_cyc(1'b1, d[i]);
      bit_cyc(last, r);
   endtask
endmodule

// ===== testbench/test_i2c_port_expander_change_alert.sv
// Self-checking bench for the port expander core
`timescale 1ns/100ps
module test_i2c_port_expander_change_alert;
   logic        sys_clk_i;     // Core clock
   logic        arst_n_i;      // Reset, active low
   logic        scl_w;         // Clock wire
   logic        sda_w;         // Data wire
   logic        scl_oe;        // Device stretch
   logic        sda_oe;        // Device data pull
   logic [15:0] port_pins_i;   // Pin levels
   logic [15:0] port_latch;    // Latch outputs
   logic        upd_ready_i;   // Update path ready
   logic        alert_oe;      // Alert pulled low
   logic        nak;           // Acknowledge level seen
   logic [7:0]  rd;            // Byte read back
   int          fail_count;    // Mismatches
   int          num_checks;    // Comparisons
   localparam logic [6:0] DEV = pxa_pkg::PXA_DEV_ADDR;
   pxa_core uut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .scl_i(scl_w), .scl_o(),
      .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe),
      .port_pins_i(port_pins_i), .port_latch_o(port_latch), .upd_ready_i(upd_ready_i),
      .alert_o(), .alert_oe_o(alert_oe));
   pxa_master_model m (.sys_clk_i(sys_clk_i), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
      .scl_w_o(scl_w), .sda_w_o(sda_w));
   // 200 MHz clock
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic set_pins(input logic [15:0] v);
      @(posedge sys_clk_i);
      port_pins_i <= v;
   endtask
   // Bounded wait for the alert level, then compare
   task automatic wait_alert(input logic lvl);
      for (int i = 0; i < 20 && alert_oe !== lvl; i++) @(negedge sys_clk_i);
      chk_bit(alert_oe, lvl);
   endtask
   task automatic sc_alert;
      set_pins(16'hFFFE);
      wait_alert(1'b1);
      set_pins(16'hFFFF);
      wait_alert(1'b0);
      set_pins(16'h7FFF);
      wait_alert(1'b1);
      set_pins(16'hFFFF);
      wait_alert(1'b0);
   endtask
   // Four bytes with the update path stalled, forcing a stretch
   task automatic sc_write;
      logic [7:0] d [4];
      d = '{8'h11, 8'h22, 8'h33, 8'h44};
      set_pins(16'hFFFE);
      wait_alert(1'b1);
      @(posedge sys_clk_i);
      upd_ready_i <= 1'b0;
      fork
         begin
            repeat (1100) @(posedge sys_clk_i);
            upd_ready_i <= 1'b1;
         end
      join_none
      m.start();
      m.wr_byte({DEV, 1'b0}, nak);
      chk_bit(nak, 1'b0);
      for (int k = 0; k < 4; k++) begin
         m.wr_byte(d[k], nak);
         chk_bit(nak, 1'b0);
      end
      m.stop();
      @(negedge sys_clk_i);
      chk_val(port_latch, 16'h4433);
      chk_bit(alert_oe, 1'b0);
      chk_bit(m.hung == 0, 1'b1);
      set_pins(16'hFFFC);
      wait_alert(1'b1);
      set_pins(16'hFFFE);
      wait_alert(1'b0);
   endtask
   // Low, high, low bytes; alert clears byte by byte
   task automatic sc_read;
      set_pins(16'h8134);
      wait_alert(1'b1);
      m.start();
      m.wr_byte({DEV, 1'b1}, nak);
      chk_bit(nak, 1'b0);
      m.rd_byte(1'b0, rd);
      port_pins_i <= 16'h8135;
      chk_val({8'h00, rd}, 16'h0034);
      @(negedge sys_clk_i);
      chk_bit(alert_oe, 1'b1);
      m.rd_byte(1'b0, rd);
      chk_val({8'h00, rd}, 16'h0081);
      @(negedge sys_clk_i);
      chk_bit(alert_oe, 1'b1);
      m.rd_byte(1'b1, rd);
      chk_val({8'h00, rd}, 16'h0035);
      @(negedge sys_clk_i);
      chk_bit(alert_oe, 1'b0);
      chk_bit(sda_oe, 1'b0);
      m.stop();
   endtask
   // Another address is ignored and writes nothing
   task automatic sc_bad_addr;
      m.start();
      m.wr_byte({DEV ^ 7'h01, 1'b0}, nak);
      chk_bit(nak, 1'b1);
      m.wr_byte(8'h00, nak);
      m.stop();
      @(negedge sys_clk_i);
      chk_val(port_latch, 16'h4433);
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk_i);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      fail_count  = 0;
      num_checks  = 0;
      arst_n_i    = 1'b0;
      port_pins_i = 16'hFFFF;
      upd_ready_i = 1'b1;
      repeat (12) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      repeat (6) @(negedge sys_clk_i);
      chk_val(port_latch, 16'hFFFF);
      chk_bit(alert_oe, 1'b0);
      sc_alert();
      sc_write();
      sc_read();
      sc_bad_addr();
      tally_and_finish();
   end
endmodule
